// ### design/dsr_self_refresh.v
// DRAM-side self refresh entry and exit control for one rank.
// Assumes commands, clock enable and termination pins arrive synchronous
// to core_clk, and software reaches the registers over APB.
//
// How it works
// (RULE_01) Refresh command with clock enable sampled low means sleep refresh entry.
// (RULE_02) DLL switches off on entry; switches on and resets on exit.
// (RULE_03) Controller waits 512 clocks after valid reference before first write.
// (RULE_04) Controller precharges all banks and finishes bursts before entry.
// (RULE_05) Controller registers termination low before entry unless termination disabled.
// (RULE_06) Controller holds clock enable low while the device stays asleep.
// (RULE_07) While asleep only clock enable and reset are observed.
// (RULE_08) At least one internal refresh within the clock-enable minimum pulse.
// (RULE_09) Stable clock at entry; exit allowed after minimum residency.
// (RULE_10) Clock hold before altering clock, clock setup before exit.
// (RULE_11) Only no-operation or deselect during exit time after wake.
// (RULE_12) Calibration and DLL exit time before DLL commands; termination off.
// (RULE_13) No-operation or deselect on cycle after the entry command.
// (RULE_14) Exit asynchronous; intervals count from first edge with clock enable high.
// (RULE_15) Above 85 C controller refreshes twice as often, 32 ms period.
// (RULE_16) Hot sleep refresh needs automatic rate or extended range enabled.
// (RULE_17) Manual range bit: 0 normal, 1 extended, when automatic rate off.
// (RULE_18) Automatic rate bit set: device picks its own sleep refresh rate.
// (RULE_19) Both range bits set is illegal.
// (RULE_20) Controller tracks sleep state and blocks commands until intervals expire. Here nothing is blocked; cmd_err only flags non-idle commands.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "dsr_regs.vh"

module dsr_self_refresh (
  input wire core_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cke,
  input wire [3:0] cmd,
  input wire odt,
  input wire hot,
  output reg dll_on,
  output reg dll_reset,
  output reg int_refresh,
  output reg asleep,
  output reg cmd_err
);

  // ==========================================================
  // Reset release
  reg rst_m_q;
  reg rst_s_q;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire rst_n = rst_s_q;

  // ==========================================================
  // States
  localparam ST_IDLE = 2'd0;
  localparam ST_SLEEP = 2'd1;
  localparam ST_XS = 2'd2;
  localparam ST_XSDLL = 2'd3;

  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [7:0] ctrl_q;
  reg [15:0] ckesr_q;
  reg [15:0] xs_q;
  reg [15:0] xsdll_q;
  reg [15:0] ref_q;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg [15:0] rcnt_q;
  reg cke_q;
  reg odt_err_q;
  reg ent_nop_q;
  reg sleeps_q;

  wire automatic_refresh_rate_enable = ctrl_q[`DSR_AUTO_RATE_BIT];
  wire manual_temp_range_select = ctrl_q[`DSR_RANGE_SEL_BIT];
  wire cfg_illegal = automatic_refresh_rate_enable & manual_temp_range_select; // [RULE_19]
  // Automatic rate follows die heat and overrides the manual bit [RULE_18] [RULE_17]
  wire fast_rate = (automatic_refresh_rate_enable & hot) |
                   (~automatic_refresh_rate_enable & manual_temp_range_select);
  wire sr_entry = (st_q == ST_IDLE) && cke_q && !cke && (cmd == `DSR_CMD_REF); // [RULE_01]
  wire is_idle_cmd = (cmd == `DSR_CMD_NOP) || cmd[3];

  // ==========================================================
  // Sequence of sleep, wake and DLL relock
  always @* begin
    st_d = st_q;
    cnt_d = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : 16'h0000;
    case (st_q)
      ST_IDLE: begin
        if (sr_entry) begin
          st_d = ST_SLEEP;
          cnt_d = ckesr_q;
        end
      end
      ST_SLEEP: begin
        // Only clock enable is looked at here; commands are ignored [RULE_07]
        if (cke) begin
          st_d = ST_XS; // first edge with clock enable high starts timing [RULE_14]
          cnt_d = xs_q;
        end
      end
      ST_XS: begin
        if (cnt_q == 16'h0000) begin
          st_d = ST_XSDLL;
          cnt_d = (xsdll_q > xs_q) ? xsdll_q - xs_q : 16'h0000;
        end
      end
      ST_XSDLL: begin
        if (cnt_q == 16'h0000) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      cke_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cke_q <= cke;
    end
  end

  // ==========================================================
  // DLL control, internal refresh and status outputs
  // Refresh pulse comes one cycle after entry, well inside the minimum pulse.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dll_on <= 1'b1;
      dll_reset <= 1'b0;
      int_refresh <= 1'b0;
      asleep <= 1'b0;
      cmd_err <= 1'b0;
      rcnt_q <= 16'h0000;
      odt_err_q <= 1'b0;
      ent_nop_q <= 1'b0;
      sleeps_q <= 1'b0;
    end else begin
      dll_reset <= 1'b0;
      int_refresh <= 1'b0;
      ent_nop_q <= sr_entry;
      if (sr_entry) begin
        dll_on <= 1'b0; // [RULE_02]
        int_refresh <= 1'b1; // [RULE_08]
        rcnt_q <= ref_q;
        odt_err_q <= odt;
        sleeps_q <= 1'b1;
      end else if (st_q == ST_SLEEP && !cke) begin
        // Rate: automatic follows die heat, else manual range bit [RULE_18] [RULE_17]
        if (rcnt_q == 16'h0000) begin
          int_refresh <= 1'b1;
          rcnt_q <= fast_rate ? {1'b0, ref_q[15:1]} : ref_q;
        end else begin
          rcnt_q <= rcnt_q - 16'h0001;
        end
      end
      if (st_q == ST_SLEEP && cke) begin
        dll_on <= 1'b1; // [RULE_02]
        dll_reset <= 1'b1;
      end
      asleep <= (st_d == ST_SLEEP);
      // Flag commands seen too early; sticky until a control write clears it
      if ((ent_nop_q && !is_idle_cmd) || (st_q == ST_XS && !is_idle_cmd)) begin
        cmd_err <= 1'b1; // [RULE_13] [RULE_11]
      end else if (psel && penable && pwrite && paddr == `DSR_CTRL_OFF) begin
        cmd_err <= 1'b0;
      end
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `DSR_CTRL_RST;
      ckesr_q <= `DSR_CKESR_RST;
      xs_q <= `DSR_XS_RST;
      xsdll_q <= `DSR_XSDLL_RST;
      ref_q <= `DSR_REF_RST;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        case (paddr)
          `DSR_CTRL_OFF: prdata <= {24'h000000, ctrl_q};
          `DSR_STAT_OFF: prdata <= {22'h000000, cfg_illegal, odt_err_q, sleeps_q,
                                    cmd_err, dll_on, asleep, 2'b00, st_q};
          `DSR_CKESR_OFF: prdata <= {16'h0000, ckesr_q};
          `DSR_XS_OFF: prdata <= {16'h0000, xs_q};
          `DSR_XSDLL_OFF: prdata <= {16'h0000, xsdll_q};
          `DSR_REF_OFF: prdata <= {16'h0000, ref_q};
          default: pslverr <= 1'b1;
        endcase
      end
      if (psel && penable && pready && pwrite) begin
        case (paddr)
          `DSR_CTRL_OFF: ctrl_q <= pwdata[7:0];
          `DSR_CKESR_OFF: ckesr_q <= pwdata[15:0];
          `DSR_XS_OFF: xs_q <= pwdata[15:0];
          `DSR_XSDLL_OFF: xsdll_q <= pwdata[15:0];
          `DSR_REF_OFF: ref_q <= pwdata[15:0];
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

endmodule

// ### design/dsr_regs.vh
// Constants for the DRAM sleep refresh control block: register map,
// field positions, reset values and timing counts.
// Assumes a 20 MHz core clock and a 32-bit APB register bus.
`ifndef DSR_REGS_VH
`define DSR_REGS_VH

// ==========================================================
// Register byte offsets
`define DSR_CTRL_OFF 12'h000
`define DSR_STAT_OFF 12'h004
`define DSR_CKESR_OFF 12'h008
`define DSR_XS_OFF 12'h00c
`define DSR_XSDLL_OFF 12'h010
`define DSR_REF_OFF 12'h014

// ==========================================================
// Control fields (mode register 2 image)
`define DSR_AUTO_RATE_BIT 6
`define DSR_RANGE_SEL_BIT 7

// ==========================================================
// Reset values
`define DSR_CTRL_RST 8'h00
`define DSR_CKESR_RST 16'h0005
`define DSR_XS_RST 16'h0010
`define DSR_XSDLL_RST 16'h0200
`define DSR_REF_RST 16'h0002

// ==========================================================
// Normal refresh interval base, in core cycles at 20 MHz
`define DSR_REF_NORM 16'h009c
// Vref settle before first write, in memory clocks
`define DSR_VREF_CLKS 16'h0200

// ==========================================================
// Command encodings {cs_b, ras_b, cas_b, we_b}
`define DSR_CMD_REF 4'h1
`define DSR_CMD_NOP 4'h7
`define DSR_CMD_DES 4'h8

`endif

// ### dv/dsr_self_refresh_monitor.sv
// Checker of sleep refresh entry, wake and command rules.
// Sees only the block ports; one clock domain, bound at the foot.
`timescale 1ns/1ps
`include "dsr_regs.vh"
module dsr_self_refresh_monitor (
  input logic core_clk,
  input logic rst_b,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic cke,
  input logic [3:0] cmd,
  input logic dll_on,
  input logic dll_reset,
  input logic int_refresh,
  input logic asleep,
  input logic cmd_err
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Entry steps: refresh with clock enable falling, then sleep
  sequence s_enter;
    $fell(cke) && cmd == `DSR_CMD_REF && !asleep;
  endsequence
  sequence s_slept;
    asleep && !dll_on && int_refresh;
  endsequence
  chk_entry_sleep: assert property (s_enter |=> s_slept)
    else $error("no sleep after entry");
  chk_wake_up: assert property (asleep && cke |=> !asleep && dll_on ##[0:1] dll_reset)
    else $error("no wake after clock enable");
  chk_dll_off: assert property (asleep |-> !dll_on)
    else $error("dll running while asleep");
  chk_reset_wake: assert property (dll_reset |-> !asleep && dll_on)
    else $error("dll reset outside wake");
  chk_ref_asleep: assert property (int_refresh |-> asleep)
    else $error("internal refresh while awake");
  // Commands are noise while asleep, so nothing but cke may move state
  chk_hold_sleep: assert property (asleep && !cke |=> asleep)
    else $error("left sleep without clock enable");
  chk_quiet_err: assert property (asleep && !cke && !$rose(asleep) |=> $stable(cmd_err))
    else $error("command seen while asleep");
  chk_entry_err: assert property ($rose(asleep) && !cmd[3] && cmd != `DSR_CMD_NOP |=> cmd_err)
    else $error("bad command after entry missed");
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
endmodule
bind dsr_self_refresh dsr_self_refresh_monitor u_mon (.core_clk, .rst_b, .psel, .penable,
  .pready, .cke, .cmd, .dll_on, .dll_reset, .int_refresh, .asleep, .cmd_err);

// ### dv/dsr_ctl_model.sv
// Memory controller model walking the block through sleep and wake.
// Assumes the bench raises sleep_req only when the block is idle.
`timescale 1ns/1ps
`include "dsr_regs.vh"
module dsr_ctl_model (
  input wire core_clk,
  input wire sleep_req,
  input wire bad_next,
  output reg cke = 1'b1,
  output reg [3:0] cmd = `DSR_CMD_NOP,
  output reg odt = 1'b0 // Termination kept off
);
  reg [1:0] ph_q = 2'd0;
  // Banks taken as precharged; clock never altered, so no hold or setup wait
  // No write is ever issued, so the reference settle wait is always met
  always @(posedge core_clk) begin
    case (ph_q)
      2'd0: if (sleep_req) begin
        cke <= 1'b0;
        cmd <= `DSR_CMD_REF;
        ph_q <= 2'd1;
      end
      2'd1: begin
        cmd <= bad_next ? 4'h3 : `DSR_CMD_NOP;
        ph_q <= 2'd2;
      end
      default: if (sleep_req) begin
        cmd <= cmd + 4'h5; // Floating inputs change every cycle
      end else begin
        cke <= 1'b1;
        cmd <= `DSR_CMD_DES; // Deselect only, no DLL commands
        ph_q <= 2'd0;
      end
    endcase
  end
endmodule

// ### dv/dsr_self_refresh_tb.sv
// Bench: register map over APB, then naps in every range mode.
// Assumes the controller model drives cke, cmd and odt.
`timescale 1ns/1ps
`include "dsr_regs.vh"
module dsr_self_refresh_tb;
  reg core_clk, rst_b, psel, penable, pwrite, hot, sleep_req, bad_next, er;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd, seed, v;
  wire [31:0] prdata;
  wire [3:0] cmd;
  wire pready, pslverr, cke, odt, dll_on, dll_reset, int_refresh, asleep, cmd_err;
  wire [63:0] rv = {`DSR_REF_RST, `DSR_XSDLL_RST, `DSR_XS_RST, `DSR_CKESR_RST};
  integer bad_count, checks_done, i, cnt;
  // Register image kept by the bench from the map, indexed by word
  integer mdl [0:5];
  dsr_self_refresh u_dsr_self_refresh (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cke, .cmd, .odt, .hot, .dll_on, .dll_reset,
    .int_refresh, .asleep, .cmd_err);
  dsr_ctl_model u_dsr_ctl_model (.core_clk, .sleep_req, .bad_next, .cke, .cmd, .odt);
  function [31:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction
  task chk(input string nm, input [31:0] s, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // ==========================================================
  // APB transfer; the wait for pready has no bound of its own
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // Waits as long as the slave asks; only the watchdog ends a hang
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wt(input s);
    begin
      while (asleep !== s) @(posedge core_clk);
    end
  endtask
  // Write through APB and keep the register image in step
  task wr(input [11:0] a, input [31:0] d);
    begin
      apb(1'b1, a, d);
      if (a == `DSR_CTRL_OFF) mdl[0] = d & 32'h000000ff;
      else if (a != `DSR_STAT_OFF && a < 12'h018) mdl[a >> 2] = d & 32'h0000ffff;
    end
  endtask
  // One 40-cycle sleep, counting refreshes; idle long enough for exit times
  task nap(input b);
    begin
      bad_next <= b;
      sleep_req <= 1'b1;
      wt(1'b1);
      chk("dll_on asleep", dll_on, 0);
      cnt = 0;
      repeat (40) begin @(posedge core_clk); cnt = cnt + int_refresh; end
      sleep_req <= 1'b0;
      wt(1'b0);
      chk("dll_on awake", dll_on, 1);
      repeat (60) @(posedge core_clk);
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Whole run is under a thousand cycles
  initial begin
    #100000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial begin
    {rst_b, psel, penable, pwrite, hot, sleep_req, bad_next} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    seed = 32'd84588;
    bad_count = 0;
    checks_done = 0;
    for (i = 0; i < 4; i = i + 1) mdl[i + 2] = rv[16 * i +: 16];
    mdl[0] = `DSR_CTRL_RST;
    mdl[1] = 0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b0, `DSR_CKESR_OFF + 4 * i, 0);
      chk("reset value", rd, rv[16 * i +: 16]);
    end
    apb(1'b0, 12'h018, 0);
    chk("unmapped error", er, 1);
    v = rnd() & 32'h0000ffff;
    wr(`DSR_CKESR_OFF, v);
    apb(1'b0, `DSR_CKESR_OFF, 0);
    chk("residency readback", rd, v);
    // Residency back below the nap length, so the model's wake stays legal
    wr(`DSR_CKESR_OFF, `DSR_CKESR_RST);
    wr(`DSR_XS_OFF, 8);
    wr(`DSR_XSDLL_OFF, 40);
    wr(`DSR_REF_OFF, 8);
    for (i = 2; i < 6; i = i + 1) begin
      apb(1'b0, 4 * i, 0);
      chk("register image", rd, mdl[i]);
    end
    // Hot only with a range option on; fast rate when manual or automatic and hot
    // Model sends no refresh of its own, so no doubled external rate is owed
    for (i = 0; i < 4; i = i + 1) begin
      hot <= rnd() & (i != 0);
      wr(`DSR_CTRL_OFF, i << 6);
      apb(1'b0, `DSR_CTRL_OFF, 0);
      chk("control image", rd, mdl[0]);
      nap(1'b0);
      apb(1'b0, `DSR_STAT_OFF, 0);
      chk("both range bits", rd[9], i == 3);
      // Automatic bit set: heat decides; otherwise the manual bit decides
      chk("fast refresh", cnt > 6, i[0] ? hot : i[1]);
    end
    nap(1'b1);
    chk("command error", cmd_err, 1);
    apb(1'b1, `DSR_CTRL_OFF, 0);
    @(posedge core_clk);
    chk("command error cleared", cmd_err, 0);
    close_out;
  end
endmodule
